// ==== fault_classifier.sv ====
// Fault type classifier comparing phase current magnitudes.
`timescale 1ns/10ps
module fault_classifier
	import fault_locator_pkg::*;
(
	input wire logic [MAG_W-1:0] ia_i,
	input wire logic [MAG_W-1:0] ib_i,
	input wire logic [MAG_W-1:0] ic_i,
	input wire logic [MAG_W-1:0] pa_i,
	input wire logic [MAG_W-1:0] pb_i,
	input wire logic [MAG_W-1:0] pc_i,
	output fault_type_t type_o
);
	logic [MAG_W-1:0] imax, imed, imin;
	logic [MAG_W-1:0] fmax, fmed, fmin;
	logic [MAG_W-1:0] fa, fb, fc;

	function automatic logic [MAG_W-1:0] absdiff(input logic [MAG_W-1:0] a,
			input logic [MAG_W-1:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction : absdiff

	// Sorts three magnitudes into maximum, median and minimum.
	task automatic sort3(input logic [MAG_W-1:0] a, input logic [MAG_W-1:0] b,
			input logic [MAG_W-1:0] c, output logic [MAG_W-1:0] mx,
			output logic [MAG_W-1:0] md, output logic [MAG_W-1:0] mn);
		logic [MAG_W-1:0] t;
		mx = a;
		md = b;
		mn = c;
		if (md > mx) begin
			t = mx;
			mx = md;
			md = t;
		end
		if (mn > md) begin
			t = md;
			md = mn;
			mn = t;
		end
		if (md > mx) begin
			t = mx;
			mx = md;
			md = t;
		end
	endtask : sort3

	// Load compensation removes the prefault current from the mid-fault current.
	assign fa = absdiff(ia_i, pa_i);
	assign fb = absdiff(ib_i, pb_i);
	assign fc = absdiff(ic_i, pc_i);

	always_comb begin
		sort3(ia_i, ib_i, ic_i, imax, imed, imin);
		sort3(fa, fb, fc, fmax, fmed, fmin);
		// Ratios are tested by scaling, so no divider is needed.
		if ({2'b00, imax} >= {imed, 2'b00}) begin
			type_o = FAULT_SINGLE;
		end else if ({2'b00, imed} >= {imin, 2'b00}) begin
			type_o = FAULT_TWO;
		end else if ({1'b0, fmax, 1'b0} >= ({2'b00, fmed} + {1'b0, fmed, 1'b0})) begin
			type_o = FAULT_SINGLE;
		end else if ({1'b0, fmed, 1'b0} > ({2'b00, fmin} + {1'b0, fmin, 1'b0})) begin
			type_o = FAULT_TWO;
		end else begin
			type_o = FAULT_THREE;
		end
	end
endmodule : fault_classifier

// ==== fault_locator_classifier.sv ====
// Fault locator: capture trigger, fault queue, classification and distance.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
// Operation
// - Locate only on capture with row-one pickup.
// - Line length 0.001 disables locating.
// - Primary ohm settings; scale by line length.
// - Negative sequence equals positive sequence impedance.
// - Classify first, then compute distance.
// - Type from current magnitudes only.
// - Classify on the cycle-five mid-record sample row.
// - Compensate with matching first-cycle prefault rows.
// - Four-to-one ratios give single or two-phase.
// - Compensated 1.5 ratios give single or two.
// - Compensated max/med below 1.5 and med/min at most 1.5: three-phase.
// - Prefault-based location corrects fault resistance; here prefault data only selects the loop reactance divisor.
// - No prefault data: plain reactance location.
// - Queue faults; process oldest first.
// - Release summary only after location done.
// - Ground fault voltage: third line difference minus drop.
// - Zero-sequence source impedance from resistance, reactance.
// - No shunt capacitance correction.
// - Capture on masked OR of rows.
// - Capture on trip, external input, manual command.
// - Eleven-cycle records, primary-unit quantities.
module fault_locator_classifier
	import fault_locator_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic [7:0] row1_i,
	input wire logic [7:0] row2_i,
	input wire logic [7:0] row4_i,
	input wire logic [7:0] row6_i,
	input wire logic trip_i,
	input wire logic outside_capture_input_i,
	input wire logic cycle_tick_i,
	input wire logic sample_valid_i,
	input wire logic prefault_ok_i,
	input wire logic [MAG_W-1:0] ia_i,
	input wire logic [MAG_W-1:0] ib_i,
	input wire logic [MAG_W-1:0] ic_i,
	input wire logic signed [MAG_W-1:0] ab_line_voltage_i,
	input wire logic signed [MAG_W-1:0] ca_line_voltage_i,
	input wire logic signed [MAG_W-1:0] zero_seq_current_i,
	output logic capture_o,
	output logic summary_valid_o,
	input wire logic summary_ready_i,
	output fault_type_t summary_type_o,
	output logic [31:0] summary_location_o
);
	// ****************************************
	// Settings
	// ****************************************
	logic [15:0] line_length_setting_reg;
	logic [15:0] zero_seq_source_resistance_reg, zero_seq_source_reactance_reg;
	logic [15:0] positive_seq_line_resistance_reg, positive_seq_line_reactance_reg;
	logic [15:0] zero_seq_line_resistance_reg, zero_seq_line_reactance_reg;
	logic [7:0] mask1_reg, mask2_reg, mask4_reg, mask6_reg;
	logic manual_pulse;
	logic wb_hit;
	logic [31:0] rd_next;

	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_length_setting_reg <= LINE_LEN_RST;
			zero_seq_source_resistance_reg <= IMP_RST;
			zero_seq_source_reactance_reg <= IMP_RST;
			positive_seq_line_resistance_reg <= IMP_RST;
			positive_seq_line_reactance_reg <= IMP_RST;
			zero_seq_line_resistance_reg <= IMP_RST;
			zero_seq_line_reactance_reg <= IMP_RST;
			mask1_reg <= MASK_RST;
			mask2_reg <= MASK_RST;
			mask4_reg <= MASK_RST;
			mask6_reg <= MASK_RST;
		end else if (ce_i && wb_hit && wb_we_i && wb_sel_i[0]) begin
			// Settings are 16 bits or less; lane 0 commits the whole value.
			unique case (wb_adr_i[7:0])
				LINE_LEN_OFS: line_length_setting_reg <= wb_dat_i[15:0];
				SRC_R0_OFS: zero_seq_source_resistance_reg <= wb_dat_i[15:0];
				SRC_X0_OFS: zero_seq_source_reactance_reg <= wb_dat_i[15:0];
				LINE_R1_OFS: positive_seq_line_resistance_reg <= wb_dat_i[15:0];
				LINE_X1_OFS: positive_seq_line_reactance_reg <= wb_dat_i[15:0];
				LINE_R0_OFS: zero_seq_line_resistance_reg <= wb_dat_i[15:0];
				LINE_X0_OFS: zero_seq_line_reactance_reg <= wb_dat_i[15:0];
				MASK1_OFS: mask1_reg <= wb_dat_i[7:0];
				MASK2_OFS: mask2_reg <= wb_dat_i[7:0];
				MASK4_OFS: mask4_reg <= wb_dat_i[7:0];
				MASK6_OFS: mask6_reg <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	assign manual_pulse = ce_i && wb_hit && wb_we_i && wb_sel_i[0] &&
		(wb_adr_i[7:0] == CTRL_OFS) && wb_dat_i[0];

	// ****************************************
	// Capture trigger
	// ****************************************
	logic [1:0] ext_sync_reg;
	logic ext_sync_d_reg;
	logic expr_reg, trip_d_reg;
	logic capture_launch_expression;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_sync_reg <= 2'b00;
			ext_sync_d_reg <= 1'b0;
		end else if (ce_i) begin
			ext_sync_reg <= {ext_sync_reg[0], outside_capture_input_i};
			ext_sync_d_reg <= ext_sync_reg[1];
		end
	end

	assign capture_launch_expression = |{row1_i & mask1_reg, row2_i & mask2_reg,
		row4_i & mask4_reg, row6_i & mask6_reg};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			expr_reg <= 1'b0;
			trip_d_reg <= 1'b0;
		end else if (ce_i) begin
			expr_reg <= capture_launch_expression;
			trip_d_reg <= trip_i;
		end
	end

	logic capture_start;
	logic recording_reg;
	assign capture_start = !recording_reg && ((capture_launch_expression && !expr_reg) ||
		(trip_i && !trip_d_reg) || (ext_sync_reg[1] && !ext_sync_d_reg) ||
		manual_pulse);

	// ****************************************
	// Record: eleven cycles, mid rows captured
	// ****************************************
	logic [3:0] cyc_cnt_reg;
	logic pickup_seen_reg;
	logic [MAG_W-1:0] mid_a_reg, mid_b_reg, mid_c_reg, pre_a_reg, pre_b_reg, pre_c_reg;
	logic signed [MAG_W-1:0] vab_reg, vca_reg, i0_reg;
	logic pre_ok_reg;
	logic record_done;

	// The record centre is cycle five; its rows are held there.
	assign record_done = recording_reg && cycle_tick_i && (cyc_cnt_reg == RECORD_CYCLES - 4'h1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			recording_reg <= 1'b0;
			cyc_cnt_reg <= 4'h0;
			pickup_seen_reg <= 1'b0;
		end else if (ce_i) begin
			if (capture_start) begin
				recording_reg <= 1'b1;
				cyc_cnt_reg <= 4'h0;
				pickup_seen_reg <= |row1_i;
			end else if (recording_reg) begin
				pickup_seen_reg <= pickup_seen_reg | (|row1_i);
				if (record_done) begin
					recording_reg <= 1'b0;
				end else if (cycle_tick_i) begin
					cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mid_a_reg <= '0;
			mid_b_reg <= '0;
			mid_c_reg <= '0;
			pre_a_reg <= '0;
			pre_b_reg <= '0;
			pre_c_reg <= '0;
			vab_reg <= '0;
			vca_reg <= '0;
			i0_reg <= '0;
			pre_ok_reg <= 1'b0;
		end else if (ce_i && recording_reg && sample_valid_i) begin
			if (cyc_cnt_reg == 4'h0) begin
				pre_a_reg <= ia_i;
				pre_b_reg <= ib_i;
				pre_c_reg <= ic_i;
				pre_ok_reg <= prefault_ok_i;
			end
			if (cyc_cnt_reg == (RECORD_CYCLES >> 1)) begin
				mid_a_reg <= ia_i;
				mid_b_reg <= ib_i;
				mid_c_reg <= ic_i;
				vab_reg <= ab_line_voltage_i;
				vca_reg <= ca_line_voltage_i;
				i0_reg <= zero_seq_current_i;
			end
		end
	end

	// ****************************************
	// Fault queue, oldest first
	// ****************************************
	localparam int unsigned ENTRY_W = 6 * MAG_W + 3 * MAG_W + 1;
	logic [ENTRY_W-1:0] queue_mem [QUEUE_DEPTH];
	logic [1:0] wr_ptr_reg, rd_ptr_reg;
	logic [2:0] count_reg;
	logic push, pop;
	logic [ENTRY_W-1:0] head;

	// Locating needs a row-one pickup and an enabled line length.
	assign push = ce_i && record_done && pickup_seen_reg && (count_reg != 3'(QUEUE_DEPTH)) &&
		(line_length_setting_reg != LINE_LEN_DISABLE);
	assign head = queue_mem[rd_ptr_reg];

	always_ff @(posedge clk_i) begin
		if (push) begin
			queue_mem[wr_ptr_reg] <= {pre_ok_reg, mid_a_reg, mid_b_reg, mid_c_reg,
				pre_a_reg, pre_b_reg, pre_c_reg, vab_reg, vca_reg, i0_reg};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= 2'h0;
			rd_ptr_reg <= 2'h0;
			count_reg <= 3'h0;
		end else if (ce_i) begin
			if (push) wr_ptr_reg <= wr_ptr_reg + 2'h1;
			if (pop) rd_ptr_reg <= rd_ptr_reg + 2'h1;
			count_reg <= count_reg + {2'b00, push} - {2'b00, pop};
		end
	end

	// ****************************************
	// Classification then location
	// ****************************************
	typedef enum logic [2:0] {IDLE, CLASSIFY, VOLT, DIVIDE, REPORT} loc_state_t;
	loc_state_t state_reg;
	fault_type_t cls_type;
	fault_type_t type_reg;
	logic signed [47:0] vnum_reg;
	logic signed [31:0] vim_reg;
	logic [47:0] num_reg, rem_reg;
	logic [31:0] quo_reg;
	logic [31:0] den;
	logic [5:0] step_reg;
	logic signed [31:0] drop_re, drop_im;
	logic signed [MAG_W-1:0] h_vab, h_vca, h_i0;
	logic [MAG_W-1:0] h_ia, h_ib, h_ic, h_pa, h_pb, h_pc;
	logic h_pre_ok;
	logic [48:0] rem_shift;

	assign {h_pre_ok, h_ia, h_ib, h_ic, h_pa, h_pb, h_pc, h_vab, h_vca, h_i0} = head;

	fault_classifier u_classifier (
		.ia_i(h_ia),
		.ib_i(h_ib),
		.ic_i(h_ic),
		.pa_i(h_pa),
		.pb_i(h_pb),
		.pc_i(h_pc),
		.type_o(cls_type)
	);

	// Source drop formed from resistance and reactance as a complex value.
	assign drop_re = $signed({1'b0, zero_seq_source_resistance_reg}) * h_i0;
	assign drop_im = $signed({1'b0, zero_seq_source_reactance_reg}) * h_i0;
	// Denominator: with prefault data, loop reactance with negative sequence taken equal to positive; otherwise positive-sequence reactance alone.
	assign den = h_pre_ok ?
		{15'h0, 17'({1'b0, positive_seq_line_reactance_reg} + {1'b0, positive_seq_line_reactance_reg})} + {16'h0, zero_seq_line_reactance_reg} :
		{16'h0, positive_seq_line_reactance_reg};
	assign rem_shift = {rem_reg, num_reg[47]};
	assign pop = ce_i && (state_reg == REPORT) && summary_ready_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= IDLE;
			type_reg <= FAULT_NONE;
			vnum_reg <= '0;
			vim_reg <= '0;
			num_reg <= '0;
			rem_reg <= '0;
			quo_reg <= '0;
			step_reg <= 6'h0;
		end else if (ce_i) begin
			unique case (state_reg)
				IDLE: if (count_reg != 3'h0) state_reg <= CLASSIFY;
				CLASSIFY: begin
					type_reg <= cls_type;
					state_reg <= VOLT;
				end
				VOLT: begin
					// Ground faults rebuild the phase voltage from line voltages; no
					// capacitance factor is applied afterwards.
					if (type_reg == FAULT_SINGLE) begin
						vnum_reg <= ((48'(h_vab) - 48'(h_vca)) * 48'sd21845 >>> 16) -
							48'(drop_re);
						vim_reg <= drop_im;
					end else begin
						vnum_reg <= 48'(h_vab);
						vim_reg <= 32'sh00000000;
					end
					state_reg <= DIVIDE;
					step_reg <= 6'h0;
					rem_reg <= '0;
					quo_reg <= '0;
				end
				DIVIDE: begin
					if (step_reg == 6'h0) begin
						// The complex magnitude is taken as the sum of both parts: no root
						// is needed, at the price of reading up to 1.41 times too far.
						num_reg <= ((vnum_reg < 0 ? 48'(-vnum_reg) : 48'(vnum_reg)) +
							(vim_reg < 0 ? 48'(-vim_reg) : 48'(vim_reg))) *
							48'(line_length_setting_reg);
						step_reg <= 6'h1;
					end else begin
						if (rem_shift >= {17'h0, den}) begin
							rem_reg <= 48'(rem_shift - {17'h0, den});
							quo_reg <= {quo_reg[30:0], 1'b1};
						end else begin
							rem_reg <= rem_shift[47:0];
							quo_reg <= {quo_reg[30:0], 1'b0};
						end
						num_reg <= {num_reg[46:0], 1'b0};
						if (step_reg == 6'(DIV_STEPS)) state_reg <= REPORT;
						step_reg <= step_reg + 6'h1;
					end
				end
				REPORT: if (summary_ready_i) state_reg <= IDLE;
				default: state_reg <= IDLE;
			endcase
		end
	end

	assign summary_valid_o = (state_reg == REPORT);
	assign summary_type_o = type_reg;
	assign summary_location_o = quo_reg;
	assign capture_o = recording_reg;

	// ****************************************
	// Bus read
	// ****************************************
	always_comb begin
		unique case (wb_adr_i[7:0])
			LINE_LEN_OFS: rd_next = {16'h0, line_length_setting_reg};
			SRC_R0_OFS: rd_next = {16'h0, zero_seq_source_resistance_reg};
			SRC_X0_OFS: rd_next = {16'h0, zero_seq_source_reactance_reg};
			LINE_R1_OFS: rd_next = {16'h0, positive_seq_line_resistance_reg};
			LINE_X1_OFS: rd_next = {16'h0, positive_seq_line_reactance_reg};
			LINE_R0_OFS: rd_next = {16'h0, zero_seq_line_resistance_reg};
			LINE_X0_OFS: rd_next = {16'h0, zero_seq_line_reactance_reg};
			STATUS_OFS: rd_next = {24'h0, count_reg, 2'b00, summary_valid_o, recording_reg,
				(state_reg != IDLE)};
			RESULT_OFS: rd_next = {30'h0, type_reg};
			LOC_OFS: rd_next = quo_reg;
			MASK1_OFS: rd_next = {24'h0, mask1_reg};
			MASK2_OFS: rd_next = {24'h0, mask2_reg};
			MASK4_OFS: rd_next = {24'h0, mask4_reg};
			MASK6_OFS: rd_next = {24'h0, mask6_reg};
			default: rd_next = UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= wb_hit;
			if (wb_hit) wb_dat_o <= rd_next;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_disabled_no_push;
		@(posedge clk_i) disable iff (rst_i)
		(line_length_setting_reg == LINE_LEN_DISABLE) |=> $stable(wr_ptr_reg);
	endproperty
	a_disabled_no_push: assert property (p_disabled_no_push)
		else $error("Fault queued while locator disabled.");

	property p_push_needs_pickup;
		@(posedge clk_i) disable iff (rst_i)
		(record_done && !pickup_seen_reg) |=> $stable(wr_ptr_reg);
	endproperty
	a_push_needs_pickup: assert property (p_push_needs_pickup)
		else $error("Fault queued without pickup.");

	property p_report_after_divide;
		@(posedge clk_i) disable iff (rst_i)
		$rose(summary_valid_o) |-> $past(state_reg) == DIVIDE;
	endproperty
	a_report_after_divide: assert property (p_report_after_divide)
		else $error("Summary released before location.");

	property p_classify_then_volt;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && state_reg == CLASSIFY) |=> state_reg == VOLT;
	endproperty
	a_classify_then_volt: assert property (p_classify_then_volt)
		else $error("Location started without classification.");

	property p_pop_order;
		@(posedge clk_i) disable iff (rst_i)
		pop |=> rd_ptr_reg == $past(rd_ptr_reg) + 2'h1;
	endproperty
	a_pop_order: assert property (p_pop_order)
		else $error("Queue not drained in order.");

	property p_record_len;
		@(posedge clk_i) disable iff (rst_i)
		$fell(recording_reg) |-> $past(cyc_cnt_reg) == 4'hA;
	endproperty
	a_record_len: assert property (p_record_len)
		else $error("Record length wrong.");

	property p_manual_capture;
		@(posedge clk_i) disable iff (rst_i)
		(manual_pulse && !recording_reg) |=> recording_reg;
	endproperty
	a_manual_capture: assert property (p_manual_capture)
		else $error("Manual capture ignored.");

	property p_trip_capture;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && trip_i && !trip_d_reg && !recording_reg) |=> recording_reg;
	endproperty
	a_trip_capture: assert property (p_trip_capture)
		else $error("Trip did not start capture.");

	property p_expr_capture;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && capture_launch_expression && !expr_reg && !recording_reg) |=> recording_reg;
	endproperty
	a_expr_capture: assert property (p_expr_capture)
		else $error("Launch expression did not start capture.");
endmodule : fault_locator_classifier

// ==== fault_locator_classifier_bench.sv ====
// Self-checking testbench of the fault locator classifier.
`timescale 1ns/10ps
module fault_locator_classifier_bench
	import fault_locator_pkg::*;
;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [31:0] wb_adr_i = 32'h00000000, wb_dat_i = 32'h00000000, wb_dat_o;
	logic [3:0] wb_sel_i = 4'hF;
	logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
	logic [7:0] row1_i = 8'h00, row2_i = 8'h00, row4_i = 8'h00, row6_i = 8'h00;
	logic trip_i = 1'b0, outside_capture_input_i = 1'b0;
	logic cycle_tick_i = 1'b0, sample_valid_i = 1'b0, prefault_ok_i = 1'b0;
	logic [MAG_W-1:0] ia_i = 16'h0000, ib_i = 16'h0000, ic_i = 16'h0000;
	logic signed [MAG_W-1:0] ab_line_voltage_i = 16'h0400, ca_line_voltage_i = 16'hFC00;
	logic signed [MAG_W-1:0] zero_seq_current_i = 16'h0010;
	logic capture_o, summary_valid_o, summary_ready_i = 1'b0;
	fault_type_t summary_type_o;
	logic [31:0] summary_location_o;
	int failures = 0;
	int tests_run = 0;

	always #2 clk_i = ~clk_i;

	fault_locator_classifier dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
		.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
		.row1_i(row1_i), .row2_i(row2_i), .row4_i(row4_i), .row6_i(row6_i),
		.trip_i(trip_i), .outside_capture_input_i(outside_capture_input_i),
		.cycle_tick_i(cycle_tick_i), .sample_valid_i(sample_valid_i),
		.prefault_ok_i(prefault_ok_i), .ia_i(ia_i), .ib_i(ib_i), .ic_i(ic_i),
		.ab_line_voltage_i(ab_line_voltage_i), .ca_line_voltage_i(ca_line_voltage_i),
		.zero_seq_current_i(zero_seq_current_i), .capture_o(capture_o),
		.summary_valid_o(summary_valid_o), .summary_ready_i(summary_ready_i),
		.summary_type_o(summary_type_o), .summary_location_o(summary_location_o)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic final_report;
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {24'h000000, adr};
		wb_dat_i <= dat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] q;
		wb(1'b1, adr, dat, q);
	endtask : wr

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, adr, 32'h00000000, q);
		chk(q, exp);
	endtask : rd

	// Kinds: 0 manual command, 1 trip, 2 outside input, 3 masked row four.
	task automatic trig(input int k);
		case (k)
			0: wr(CTRL_OFS, 32'h00000001);
			1: trip_i <= 1'b1;
			2: outside_capture_input_i <= 1'b1;
			default: begin
				wr(MASK4_OFS, 32'h00000001);
				@(posedge clk_i);
				row4_i <= 8'h01;
			end
		endcase
	endtask : trig

	// Feeds one eleven-cycle record: prefault rows in cycle 0, fault rows after.
	task automatic record(input logic [7:0] r1, input logic pok, input logic [15:0] pa,
			input logic [15:0] pb, input logic [15:0] pc, input logic [15:0] fa,
			input logic [15:0] fb, input logic [15:0] fc);
		int i;
		int n;
		n = 0;
		row1_i <= r1;
		prefault_ok_i <= pok;
		while (capture_o !== 1'b1 && n < 10) begin
			@(posedge clk_i);
			n++;
		end
		chk({31'h0, capture_o}, 32'h1);
		trip_i <= 1'b0;
		outside_capture_input_i <= 1'b0;
		row4_i <= 8'h00;
		for (i = 0; i < 11; i++) begin
			{ia_i, ib_i, ic_i} <= (i == 0) ? {pa, pb, pc} : {fa, fb, fc};
			@(posedge clk_i);
			sample_valid_i <= 1'b1;
			@(posedge clk_i);
			sample_valid_i <= 1'b0;
			cycle_tick_i <= 1'b1;
			chk({31'h0, capture_o}, 32'h1);
			@(posedge clk_i);
			cycle_tick_i <= 1'b0;
		end
		@(posedge clk_i);
		chk({31'h0, capture_o}, 32'h0);
		row1_i <= 8'h00;
	endtask : record

	// Waits for the next summary, compares it and pops it.
	task automatic take(input fault_type_t t, input logic [31:0] loc);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (summary_valid_o !== 1'b1 && n < 300);
		if (n >= 300) begin
			failures++;
		end
		chk({30'h0, summary_type_o}, {30'h0, t});
		chk(summary_location_o, loc);
		rd(RESULT_OFS, {30'h0, t});
		rd(LOC_OFS, loc);
		@(posedge clk_i);
		summary_ready_i <= 1'b1;
		@(posedge clk_i);
		summary_ready_i <= 1'b0;
	endtask : take

	task automatic none;
		int n;
		int seen;
		seen = 0;
		for (n = 0; n < 150; n++) begin
			@(posedge clk_i);
			if (summary_valid_o !== 1'b0) begin
				seen++;
			end
		end
		chk(seen, 0);
	endtask : none

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(LINE_LEN_OFS, 32'h000003E8);
		rd(SRC_R0_OFS, 32'h00000001);
		rd(MASK6_OFS, 32'h00000000);
		wr(LINE_X1_OFS, 32'hFFFF1234);
		rd(LINE_X1_OFS, 32'h00001234);
		wr(LINE_X1_OFS, 32'h00000001);
		wr(8'h40, 32'h0000ABCD);
		rd(8'h40, UNMAPPED_DATA);
		trig(0);
		record(8'h01, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0FA0, 16'h0064, 16'h0064);
		take(FAULT_SINGLE, 32'h00000003);
		trig(1);
		record(8'h02, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0FA0, 16'h0FA0, 16'h0064);
		take(FAULT_TWO, 32'h00000005);
		trig(2);
		record(8'h01, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h03E8, 16'h01F4, 16'h0190);
		take(FAULT_SINGLE, 32'h0000000A);
		trig(3);
		record(8'h04, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h03E8, 16'h03E8, 16'h03E8);
		take(FAULT_THREE, 32'h00000005);
		trig(0);
		record(8'h01, 1'b1, 16'h0190, 16'h0190, 16'h0000, 16'h03E8, 16'h03E8, 16'h03E8);
		take(FAULT_SINGLE, 32'h00000003);
		trig(1);
		record(8'h01, 1'b1, 16'h0000, 16'h0000, 16'h0190, 16'h03E8, 16'h03E8, 16'h03E8);
		trig(0);
		record(8'h01, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0FA0, 16'h0064, 16'h0064);
		take(FAULT_TWO, 32'h00000005);
		take(FAULT_SINGLE, 32'h00000003);
		trig(0);
		record(8'h00, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0FA0, 16'h0064, 16'h0064);
		none();
		wr(LINE_LEN_OFS, {16'h0000, LINE_LEN_DISABLE});
		trig(1);
		record(8'h01, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0FA0, 16'h0064, 16'h0064);
		none();
		final_report();
	end

	// A hang is cut short well after the scenarios should have ended.
	initial begin
		#160000;
		failures++;
		final_report();
	end
endmodule : fault_locator_classifier_bench

// ==== fault_locator_pkg.sv ====
// Package with constants, register map and types of the fault locator classifier.
package fault_locator_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int unsigned MAG_W = 16;
	localparam int unsigned ROW_W = 8;
	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] LINE_LEN_OFS = 8'h04;
	localparam logic [7:0] SRC_R0_OFS = 8'h08;
	localparam logic [7:0] SRC_X0_OFS = 8'h0C;
	localparam logic [7:0] LINE_R1_OFS = 8'h10;
	localparam logic [7:0] LINE_X1_OFS = 8'h14;
	localparam logic [7:0] LINE_R0_OFS = 8'h18;
	localparam logic [7:0] LINE_X0_OFS = 8'h1C;
	localparam logic [7:0] STATUS_OFS = 8'h20;
	localparam logic [7:0] RESULT_OFS = 8'h24;
	localparam logic [7:0] LOC_OFS = 8'h28;
	localparam logic [7:0] MASK1_OFS = 8'h2C;
	localparam logic [7:0] MASK2_OFS = 8'h30;
	localparam logic [7:0] MASK4_OFS = 8'h34;
	localparam logic [7:0] MASK6_OFS = 8'h38;
	// Line length in thousandths; one thousandth disables the locator.
	localparam logic [15:0] LINE_LEN_DISABLE = 16'h0001;
	localparam logic [15:0] LINE_LEN_RST = 16'h03E8;
	localparam logic [15:0] IMP_RST = 16'h0001;
	localparam logic [7:0] MASK_RST = 8'h00;
	// Record length in cycles and the sample rows that matter.
	localparam logic [3:0] RECORD_CYCLES = 4'hB;
	localparam int unsigned QUEUE_DEPTH = 4;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	// Fixed-point location arithmetic: quotient bits.
	localparam int unsigned DIV_STEPS = 32;
	typedef enum logic [1:0] {
		FAULT_NONE,
		FAULT_SINGLE,
		FAULT_TWO,
		FAULT_THREE
	} fault_type_t;
endpackage : fault_locator_pkg
